// file: rtl/optical_module_mgmt_pkg.sv
// Constants, types and state layout of the optical module management port
package optical_module_mgmt_pkg;
  localparam logic [6:0] DEV_ID_MAP = 7'h50;
  localparam logic [6:0] DEV_DIAG_MAP = 7'h51;
  localparam int MEM_AW = 9;
  localparam int NUM_MON = 5;
  localparam logic [7:0] DIAG_VALUE_BASE = 8'h60;
  localparam logic [7:0] DIAG_VALUE_LAST = 8'h69;
  localparam logic [7:0] DIAG_ALARM_BYTE = 8'h70;
  localparam logic [7:0] DIAG_WARN_BYTE = 8'h74;
  localparam logic [7:0] DIAG_USER_BASE = 8'h80;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // Channel index: 0 temperature, 1 supply, 2 bias, 3 tx power, 4 rx power
  typedef logic [NUM_MON-1:0][15:0] mon_vec_t;
  localparam mon_vec_t ALARM_HI = {16'hFF00, 16'hFF00, 16'hFF00, 16'hFF00, 16'hFF00};
  localparam mon_vec_t WARN_HI = {16'hF000, 16'hF000, 16'hF000, 16'hF000, 16'hF000};
  localparam mon_vec_t WARN_LO = {16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0200};
  localparam mon_vec_t ALARM_LO = {16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0100};
  localparam mon_vec_t CAL_OFFSET = {16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h0010};

  typedef enum logic [2:0] {
    LS_IDLE, LS_DEV, LS_WADR, LS_WDATA, LS_RDATA, LS_ACK_OUT, LS_ACK_IN
  } link_state_e;

  typedef struct packed {
    logic scl_s1; logic scl_s2; logic scl_s3;
    logic sda_s1; logic sda_s2; logic sda_s3;
    logic flt_s1; logic flt_s2;
    logic off_s1; logic off_s2;
    logic det_s1; logic det_s2;
    link_state_e st;
    link_state_e ack_next;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic map_diag;
    logic ack_phase;
    logic ack_ok;
    logic mem_we;
    logic [MEM_AW-1:0] mem_wadr;
    logic [7:0] mem_wdat;
    logic sda_o;
    logic sda_oe;
    logic pres_o;
    logic pres_oe;
    logic tx_fault;
    logic laser_on;
    logic rx_lost;
    logic rx_en;
    mon_vec_t reading;
    logic [2*NUM_MON-1:0] alarm;
    logic [2*NUM_MON-1:0] warn;
  } mgmt_state_s;

  // Synchronisers start at the idle level of their pins: no false edge after reset,
  // and the transmitter stays off until the transmit-off pin has really been seen low
  localparam mgmt_state_s STATE_RST = '{pres_oe: 1'b1, st: LS_IDLE, ack_next: LS_IDLE,
                                        scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
                                        sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
                                        off_s1: 1'b1, off_s2: 1'b1, default: '0};
endpackage : optical_module_mgmt_pkg

// file: rtl/mgmt_map_mem.sv
// Byte memory holding both management maps, registered read data
`timescale 1ns/1ns
module mgmt_map_mem (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [optical_module_mgmt_pkg::MEM_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [optical_module_mgmt_pkg::MEM_AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1 << optical_module_mgmt_pkg::MEM_AW)-1];

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : mgmt_map_mem

// file: rtl/optical_module_mgmt_port.sv
// Management port of the optical module: two-wire slave, status pins, diagnostics
//
// Behaviour
// - Fault output high while laser fault present
// - Transmitter off while transmit-off input high
// - Presence pin held at ground always
// - Signal-lost output high when no signal
// - Answer address 1010000X, 256-byte identification map
// - Diagnostic map at 1010001X, identification map unchanged
// - Sample on clock rise; write unprotected only
// - Change driven data on clock fall
// - Data line bidirectional; start/stop by host
// - Byte words, single or sequential access
// - Live readings of five monitors readable
// - Alarm and warning flags outside range
// - Internal calibration by default, external selectable
// - Received data passes while signal present
// - Signal-lost: 0 normal, 1 lost
`timescale 1ns/1ns
module optical_module_mgmt_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic id_link_clock_pin,
  input wire logic id_link_data_pin_i,
  output logic id_link_data_pin_o,
  output logic id_link_data_pin_oe,
  output logic presence_pin_o,
  output logic presence_pin_oe,
  input wire logic tx_off_pin,
  input wire logic laser_fault,
  output logic tx_fault,
  output logic laser_on,
  input wire logic signal_detect,
  output logic rx_signal_lost,
  output logic rx_data_enable,
  input wire logic cal_external,
  input wire optical_module_mgmt_pkg::mon_vec_t monitor_raw,
  output logic [2*optical_module_mgmt_pkg::NUM_MON-1:0] alarm_flags,
  output logic [2*optical_module_mgmt_pkg::NUM_MON-1:0] warn_flags
);
  optical_module_mgmt_pkg::mgmt_state_s r;
  optical_module_mgmt_pkg::mgmt_state_s d;
  optical_module_mgmt_pkg::mon_vec_t cal_w;
  logic [2*optical_module_mgmt_pkg::NUM_MON-1:0] alarm_w;
  logic [2*optical_module_mgmt_pkg::NUM_MON-1:0] warn_w;
  logic [7:0] mem_rdata;
  logic [7:0] rd_byte;
  logic [7:0] in_byte;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] voff;

  function automatic logic writable(input logic [optical_module_mgmt_pkg::MEM_AW-1:0] a);
    writable = a[8] && (a[7:0] >= optical_module_mgmt_pkg::DIAG_USER_BASE);
  endfunction : writable

  // Per channel calibration and range flags; flags follow the reported value
  for (genvar k = 0; k < optical_module_mgmt_pkg::NUM_MON; k++) begin : g_mon
    assign cal_w[k] = cal_external ? monitor_raw[k] :
                      16'(monitor_raw[k] + optical_module_mgmt_pkg::CAL_OFFSET[k]);
    assign alarm_w[9-2*k] = cal_w[k] > optical_module_mgmt_pkg::ALARM_HI[k];
    assign alarm_w[8-2*k] = cal_w[k] < optical_module_mgmt_pkg::ALARM_LO[k];
    assign warn_w[9-2*k] = cal_w[k] > optical_module_mgmt_pkg::WARN_HI[k];
    assign warn_w[8-2*k] = cal_w[k] < optical_module_mgmt_pkg::WARN_LO[k];
  end

  mgmt_map_mem u_mem (
    .sys_clk(sys_clk),
    .we(r.mem_we),
    .waddr(r.mem_wadr),
    .wdata(r.mem_wdat),
    .raddr({r.map_diag, r.ptr}),
    .rdata(mem_rdata)
  );

  // Edges seen on the second and third stages only
  assign scl_rise = r.scl_s2 & ~r.scl_s3;
  assign scl_fall = ~r.scl_s2 & r.scl_s3;
  assign bus_start = r.scl_s2 & r.scl_s3 & ~r.sda_s2 & r.sda_s3;
  assign bus_stop = r.scl_s2 & r.scl_s3 & r.sda_s2 & ~r.sda_s3;
  assign in_byte = {r.shreg[6:0], r.sda_s2};
  assign voff = r.ptr - optical_module_mgmt_pkg::DIAG_VALUE_BASE;

  // Live values overlay the stored diagnostic map so reads are never stale
  always_comb begin
    rd_byte = mem_rdata;
    if (r.map_diag && r.ptr >= optical_module_mgmt_pkg::DIAG_VALUE_BASE &&
        r.ptr <= optical_module_mgmt_pkg::DIAG_VALUE_LAST) begin
      rd_byte = voff[0] ? r.reading[voff[3:1]][7:0] : r.reading[voff[3:1]][15:8];
    end else if (r.map_diag && r.ptr == optical_module_mgmt_pkg::DIAG_ALARM_BYTE) begin
      rd_byte = r.alarm[9:2];
    end else if (r.map_diag && r.ptr == optical_module_mgmt_pkg::DIAG_ALARM_BYTE + 8'h01) begin
      rd_byte = {r.alarm[1:0], 6'h00};
    end else if (r.map_diag && r.ptr == optical_module_mgmt_pkg::DIAG_WARN_BYTE) begin
      rd_byte = r.warn[9:2];
    end else if (r.map_diag && r.ptr == optical_module_mgmt_pkg::DIAG_WARN_BYTE + 8'h01) begin
      rd_byte = {r.warn[1:0], 6'h00};
    end
  end

  always_comb begin
    d = r;
    d.scl_s1 = id_link_clock_pin;
    d.scl_s2 = r.scl_s1;
    d.scl_s3 = r.scl_s2;
    d.sda_s1 = id_link_data_pin_i;
    d.sda_s2 = r.sda_s1;
    d.sda_s3 = r.sda_s2;
    d.flt_s1 = laser_fault;
    d.flt_s2 = r.flt_s1;
    d.off_s1 = tx_off_pin;
    d.off_s2 = r.off_s1;
    d.det_s1 = signal_detect;
    d.det_s2 = r.det_s1;
    d.tx_fault = r.flt_s2;
    d.laser_on = ~r.off_s2;
    d.rx_lost = ~r.det_s2;
    d.rx_en = r.det_s2;
    d.pres_o = 1'b0;
    d.pres_oe = 1'b1;
    d.sda_o = 1'b0;
    d.reading = cal_w;
    d.alarm = alarm_w;
    d.warn = warn_w;
    d.mem_we = 1'b0;
    if (bus_start) begin
      d.st = optical_module_mgmt_pkg::LS_DEV;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      d.st = optical_module_mgmt_pkg::LS_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (r.st)
        optical_module_mgmt_pkg::LS_DEV, optical_module_mgmt_pkg::LS_WADR,
        optical_module_mgmt_pkg::LS_WDATA: begin
          if (scl_rise) begin
            d.shreg = in_byte;
            d.cnt = r.cnt + 4'h1;
            if (r.cnt == optical_module_mgmt_pkg::LAST_BIT) begin
              d.cnt = 4'h0;
              d.ack_phase = 1'b0;
              d.st = optical_module_mgmt_pkg::LS_ACK_OUT;
              d.ack_next = optical_module_mgmt_pkg::LS_WDATA;
              if (r.st == optical_module_mgmt_pkg::LS_DEV) begin
                if (in_byte[7:1] == optical_module_mgmt_pkg::DEV_ID_MAP ||
                    in_byte[7:1] == optical_module_mgmt_pkg::DEV_DIAG_MAP) begin
                  d.map_diag = in_byte[1];
                  d.ack_next = in_byte[0] ? optical_module_mgmt_pkg::LS_RDATA :
                               optical_module_mgmt_pkg::LS_WADR;
                end else begin
                  d.st = optical_module_mgmt_pkg::LS_IDLE;
                end
              end else if (r.st == optical_module_mgmt_pkg::LS_WADR) begin
                d.ptr = in_byte;
              end else begin
                d.mem_we = writable({r.map_diag, r.ptr});
                d.mem_wadr = {r.map_diag, r.ptr};
                d.mem_wdat = in_byte;
                d.ptr = r.ptr + 8'h01;
              end
            end
          end
        end
        optical_module_mgmt_pkg::LS_ACK_OUT: begin
          if (scl_fall && !r.ack_phase) begin
            d.sda_oe = 1'b1;
            d.ack_phase = 1'b1;
          end else if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.st = r.ack_next;
            if (r.ack_next == optical_module_mgmt_pkg::LS_RDATA) begin
              d.shreg = rd_byte;
              d.sda_oe = ~rd_byte[7];
            end
          end
        end
        optical_module_mgmt_pkg::LS_RDATA: begin
          if (scl_rise) begin
            d.cnt = r.cnt + 4'h1;
            if (r.cnt == optical_module_mgmt_pkg::LAST_BIT) begin
              d.cnt = 4'h0;
              d.ack_phase = 1'b0;
              d.ptr = r.ptr + 8'h01;
              d.st = optical_module_mgmt_pkg::LS_ACK_IN;
            end
          end else if (scl_fall && r.cnt != 4'h0) begin
            d.shreg = {r.shreg[6:0], 1'b0};
            d.sda_oe = ~r.shreg[6];
          end
        end
        optical_module_mgmt_pkg::LS_ACK_IN: begin
          if (scl_fall && !r.ack_phase) begin
            d.sda_oe = 1'b0;
            d.ack_phase = 1'b1;
          end else if (scl_rise && r.ack_phase) begin
            d.ack_ok = ~r.sda_s2;
          end else if (scl_fall) begin
            // A missing acknowledge ends the read; the host then sends a stop
            d.st = r.ack_ok ? optical_module_mgmt_pkg::LS_RDATA : optical_module_mgmt_pkg::LS_IDLE;
            d.shreg = rd_byte;
            d.sda_oe = r.ack_ok & ~rd_byte[7];
          end
        end
        default: begin
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r <= optical_module_mgmt_pkg::STATE_RST;
    end else begin
      r <= d;
    end
  end

  assign id_link_data_pin_o = r.sda_o;
  assign id_link_data_pin_oe = r.sda_oe;
  assign presence_pin_o = r.pres_o;
  assign presence_pin_oe = r.pres_oe;
  assign tx_fault = r.tx_fault;
  assign laser_on = r.laser_on;
  assign rx_signal_lost = r.rx_lost;
  assign rx_data_enable = r.rx_en;
  assign alarm_flags = r.alarm;
  assign warn_flags = r.warn;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_FAULT: assert property (r.flt_s2 |=> tx_fault)
    else $error("fault output not following laser fault");
  AST_TXOFF: assert property (r.off_s2 |=> !laser_on)
    else $error("transmitter on while transmit-off high");
  AST_PRESENCE: assert property ($past(rst_n) |-> presence_pin_oe && !presence_pin_o)
    else $error("presence pin not held low");
  AST_LOS: assert property ($fell(r.det_s2) |=> rx_signal_lost && !rx_data_enable)
    else $error("signal lost not flagged");
  AST_BADADDR: assert property (r.st == optical_module_mgmt_pkg::LS_DEV && scl_rise &&
    r.cnt == optical_module_mgmt_pkg::LAST_BIT && !bus_start && !bus_stop &&
    in_byte[7:2] != 6'h28 |=> r.st == optical_module_mgmt_pkg::LS_IDLE)
    else $error("foreign device address accepted");
  AST_DRIVE_EDGE: assert property ($rose(id_link_data_pin_oe) |-> $past(scl_fall))
    else $error("data driven off the falling clock edge");
  AST_PROTECT: assert property (r.mem_we |-> r.mem_wadr[8] &&
    r.mem_wadr[7:0] >= optical_module_mgmt_pkg::DIAG_USER_BASE)
    else $error("write reached a protected byte");
  AST_RD_INC: assert property (r.st == optical_module_mgmt_pkg::LS_RDATA && scl_rise &&
    r.cnt == optical_module_mgmt_pkg::LAST_BIT && !bus_start && !bus_stop
    |=> r.ptr == 8'($past(r.ptr) + 8'h01))
    else $error("address did not advance after a read byte");
  AST_ALARM: assert property (!cal_external && monitor_raw[0] > 16'hFEF0 &&
    monitor_raw[0] < 16'hFFF0 |=> alarm_flags[9])
    else $error("temperature high alarm missing");
  AST_ACK_LOW: assert property (r.st == optical_module_mgmt_pkg::LS_ACK_OUT && r.ack_phase
    && !scl_fall && !bus_start && !bus_stop |=> id_link_data_pin_oe)
    else $error("acknowledge released early");

  COV_READ: cover property (r.st == optical_module_mgmt_pkg::LS_ACK_IN ##[1:400]
    r.st == optical_module_mgmt_pkg::LS_RDATA);
  COV_WRITE: cover property (r.mem_we);
  COV_DIAG: cover property (r.map_diag && r.st == optical_module_mgmt_pkg::LS_RDATA);
  COV_NACK: cover property (r.st == optical_module_mgmt_pkg::LS_ACK_IN ##1
    r.st == optical_module_mgmt_pkg::LS_IDLE);
endmodule : optical_module_mgmt_port

// file: verification/link_host_model.sv
// Host-side two-wire bus master model driving the module's management link
`timescale 1ns/1ns
module link_host_model (
  input wire logic dev_o,
  input wire logic dev_oe,
  output logic scl,
  output logic sda
);
  logic drv_low;

  // Open-drain wire with the host-board pull-up; either party may pull it low
  assign sda = ~(drv_low | (dev_oe & ~dev_o));

  initial begin
    scl = 1'b1;
    drv_low = 1'b0;
  end

  // Release comes well before the clock rises so a late device release never looks like a stop
  task automatic start();
    #20 drv_low = 1'b0;
    #20 scl = 1'b1;
    #40 drv_low = 1'b1;
    #40 scl = 1'b0;
  endtask : start

  task automatic stop();
    #20 drv_low = 1'b1;
    #20 scl = 1'b1;
    #40 drv_low = 1'b0;
    #40;
  endtask : stop

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #20 drv_low = ~b[i];
      #20 scl = 1'b1;
      #40 scl = 1'b0;
    end
    #20 drv_low = 1'b0;
    #20 scl = 1'b1;
    #20 ack = ~sda;
    #20 scl = 1'b0;
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #20 drv_low = 1'b0;
      #20 scl = 1'b1;
      #20 b[i] = sda;
      #20 scl = 1'b0;
    end
    // Every byte but the last is acknowledged, so the device lets go before the stop
    #20 drv_low = ~last;
    #20 scl = 1'b1;
    #40 scl = 1'b0;
  endtask : recv_byte
endmodule : link_host_model

// file: verification/optical_module_mgmt_port_bench.sv
// Self-checking bench for the optical module management port
`timescale 1ns/1ns
module optical_module_mgmt_port_bench;
  logic sys_clk, rst_n, scl, sda, sda_o, sda_oe, pres_o, pres_oe;
  logic tx_off_pin, laser_fault, tx_fault, laser_on, signal_detect;
  logic rx_signal_lost, rx_data_enable, cal_external;
  optical_module_mgmt_pkg::mon_vec_t monitor_raw;
  logic [9:0] alarm_flags, warn_flags;
  int failures = 0;
  int total_checks = 0;
  logic [7:0] e[$];

  optical_module_mgmt_port dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .id_link_clock_pin(scl),
    .id_link_data_pin_i(sda), .id_link_data_pin_o(sda_o), .id_link_data_pin_oe(sda_oe),
    .presence_pin_o(pres_o), .presence_pin_oe(pres_oe), .tx_off_pin(tx_off_pin),
    .laser_fault(laser_fault), .tx_fault(tx_fault), .laser_on(laser_on),
    .signal_detect(signal_detect), .rx_signal_lost(rx_signal_lost),
    .rx_data_enable(rx_data_enable), .cal_external(cal_external),
    .monitor_raw(monitor_raw), .alarm_flags(alarm_flags), .warn_flags(warn_flags)
  );

  link_host_model host_u (.dev_o(sda_o), .dev_oe(sda_oe), .scl(scl), .sda(sda));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : ticks

  task automatic xb(input logic [7:0] b, input logic exp_ack);
    logic a;
    host_u.send_byte(b, a);
    check(a, exp_ack);
  endtask : xb

  task automatic wr(input logic [6:0] dev, input logic [7:0] adr, input logic [7:0] d[$]);
    host_u.start();
    xb({dev, 1'b0}, 1'b1);
    xb(adr, 1'b1);
    foreach (d[i]) xb(d[i], 1'b1);
    host_u.stop();
  endtask : wr

  task automatic rd(input logic [6:0] dev, input logic [7:0] adr, input logic [7:0] x[$]);
    logic [7:0] v;
    host_u.start();
    xb({dev, 1'b0}, 1'b1);
    xb(adr, 1'b1);
    host_u.start();
    xb({dev, 1'b1}, 1'b1);
    foreach (x[i]) begin
      host_u.recv_byte(i == x.size() - 1, v);
      check(v, x[i]);
    end
    host_u.stop();
  endtask : rd

  // Raw reading of channel k; all sit inside the normal range
  function automatic logic [15:0] raw_of(input int k);
    return 16'h4000 + 16'(k) * 16'h0111;
  endfunction : raw_of

  initial begin
    repeat (50000) @(posedge sys_clk);
    failures++;
    wrap_up();
  end

  initial begin
    logic [15:0] v;
    rst_n = 1'b0;
    {tx_off_pin, laser_fault, signal_detect, cal_external} = 4'h9;
    for (int k = 0; k < 5; k++) monitor_raw[k] = raw_of(k);
    ticks(5);
    rst_n = 1'b1;
    ticks(6);
    check({pres_oe, pres_o}, 16'h0002);
    for (int i = 0; i < 8; i++) begin
      {laser_fault, tx_off_pin, signal_detect} = 3'(i);
      ticks(4);
      check(tx_fault, 16'(i[2]));
      check(laser_on, 16'(!i[1]));
      check(rx_signal_lost, 16'(!i[0]));
      check(rx_data_enable, 16'(i[0]));
    end
    cal_external = 1'b0;
    ticks(4);
    e = {};
    for (int k = 0; k < 5; k++) begin
      v = raw_of(k) + 16'h0010;
      e.push_back(v[15:8]);
      e.push_back(v[7:0]);
    end
    rd(optical_module_mgmt_pkg::DEV_DIAG_MAP, 8'h60, e);
    cal_external = 1'b1;
    ticks(4);
    v = raw_of(1);
    rd(optical_module_mgmt_pkg::DEV_DIAG_MAP, 8'h62, {v[15:8], v[7:0]});
    wr(optical_module_mgmt_pkg::DEV_DIAG_MAP, 8'h80, {8'h5A, 8'hA5, 8'h3C});
    rd(optical_module_mgmt_pkg::DEV_DIAG_MAP, 8'h80, {8'h5A, 8'hA5, 8'h3C});
    // First byte lands on a protected location, the second on user space
    wr(optical_module_mgmt_pkg::DEV_DIAG_MAP, 8'h7F, {8'hAB, 8'h11});
    rd(optical_module_mgmt_pkg::DEV_DIAG_MAP, 8'h80, {8'h11, 8'hA5});
    monitor_raw[0] = 16'hFF80;
    monitor_raw[1] = 16'h0050;
    monitor_raw[2] = 16'hF800;
    ticks(4);
    check(alarm_flags, 16'h0240);
    check(warn_flags, 16'h0260);
    rd(optical_module_mgmt_pkg::DEV_DIAG_MAP, 8'h70, {8'h90, 8'h00});
    rd(optical_module_mgmt_pkg::DEV_DIAG_MAP, 8'h74, {8'h98});
    // FF00 only crosses the high alarm limit once the internal offset is added
    monitor_raw[0] = 16'hFF00;
    cal_external = 1'b0;
    ticks(4);
    check(alarm_flags, 16'h0240);
    cal_external = 1'b1;
    ticks(4);
    check(alarm_flags, 16'h0040);
    // A foreign device address must stay unanswered
    host_u.start();
    xb(8'hA4, 1'b0);
    host_u.stop();
    wr(optical_module_mgmt_pkg::DEV_ID_MAP, 8'h00, {8'h55});
    host_u.start();
    xb({optical_module_mgmt_pkg::DEV_ID_MAP, 1'b1}, 1'b1);
    host_u.recv_byte(1'b1, v[7:0]);
    host_u.stop();
    check(sda_oe, 16'h0000);
    ticks(10);
    wrap_up();
  end
endmodule : optical_module_mgmt_port_bench
